/* core/emb_bus_if.sv */
/*
  External memory bus interface: multiplexed address/data bus with
  code, read and write strobes, address latch pulse, wait stretching,
  reset-time strapping and an AXI4-Lite configuration port.
  Assumes pins arrive asynchronously and are synchronised here; the
  core-side request port is on core_clk.
*/
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "emb_regs.svh"

// Function
// - 8 or 16 data bits, 24 address lines
// - Code strobe low only during code reads
// - Read strobe only for data reads
// - Low write strobe qualifies low byte
// - High write strobe qualifies high byte
// - Latch pulse while address on lines
// - Lowest four address lines driven throughout
// - Address first, data only after latching
// - Wait high holds strobe asserted
// - Strap low: all code fetches external
// - Strap high: external above on-chip limit
// - Code strap latched at reset release
// - Width pin low 8-bit, high 16-bit
// - Width strap overridden by config write
// - Wait ignore bit disables stretching
// - Bus off bit stops bus permanently
// - Shape codes select width and lines
// - Two idle clocks between bus cycles
// - 8-bit word: two bytes, one latch
// - 16-bit write strobes by byte lane
module emb_bus_if #(
  parameter int          ALE_CYC    = `EMB_ALE_CYC,
  parameter int          STRB_CYC   = `EMB_STRB_CYC,
  parameter logic [23:0] CODE_LIMIT = 24'h008000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        req_valid,
  output      logic        req_ready,
  input  wire logic [1:0]  req_kind,
  input  wire logic [23:0] req_addr,
  input  wire logic        req_word,
  input  wire logic [15:0] req_wdata,
  output      logic        rsp_valid,
  output      logic        rsp_skip,
  output      logic [15:0] rsp_rdata,
  output      logic        code_fetch_strobe_n,
  output      logic        read_strobe_n,
  output      logic        low_byte_write_strobe_n,
  output      logic        high_byte_write_strobe_n,
  output      logic        addr_latch_en,
  output      logic [3:0]  addr_low,
  output      logic [3:0]  addr_top,
  output      logic [15:0] mux_out,
  output      logic        mux_oe,
  input  wire logic [15:0] mux_in,
  input  wire logic        wait_in,
  input  wire logic        external_code_select_n,
  input  wire logic        width_select_pin
);

  // ==================================================================
  // Elaboration checks
  if (ALE_CYC < 1 || ALE_CYC > 16 || STRB_CYC < 3 || STRB_CYC > 16) begin : g_chk
    $error("emb_bus_if: cycle counts out of range");
  end

  localparam logic [3:0] ALE_LD  = 4'(ALE_CYC - 1);
  localparam logic [3:0] STRB_LD = 4'(STRB_CYC - 1);

  // ==================================================================
  // Helpers
  function automatic logic is16(input logic [2:0] shape);
    return shape[2:1] == 2'b11;
  endfunction

  // Reserved codes fall back to the widest 8-bit shape
  function automatic logic [23:0] amask(input logic [2:0] shape);
    case (shape)
      3'h0:    amask = 24'h000fff;
      3'h1:    amask = 24'h00ffff;
      3'h2:    amask = 24'h0fffff;
      3'h6:    amask = 24'h0fffff;
      default: amask = 24'hffffff;
    endcase
  endfunction

  function automatic logic [15:0] lane(input logic b16, input logic word,
                                       input logic a0, input logic sec,
                                       input logic [15:0] d);
    if (!b16)
      lane = {8'h00, sec ? d[15:8] : d[7:0]};
    else if (word)
      lane = d;
    else
      lane = a0 ? {d[7:0], 8'h00} : {8'h00, d[7:0]};
  endfunction

  // ==================================================================
  // State
  emb_pkg::emb_state_s q;
  emb_pkg::emb_state_s n;

  logic        bus16;
  logic        wait_act;
  logic        running;
  logic        burst_ok;
  logic [23:0] m_req;
  logic [23:0] m_cur;
  logic [7:0]  byte_in;

  assign bus16    = is16(q.shape);
  assign wait_act = q.wait_s2 && !q.wait_ign;
  assign running  = !q.bus_off && (q.st == emb_pkg::S_STRB);
  assign m_req    = req_addr & amask(q.shape);
  assign m_cur    = q.addr & amask(q.shape);
  assign byte_in  = q.din_s2[7:0];

  // Sequential code in the same 16-byte block keeps the strobe low
  assign burst_ok = req_valid && (emb_pkg::emb_kind_e'(req_kind) == emb_pkg::K_CODE)
                    && (q.kind == emb_pkg::K_CODE) && !q.second
                    && (m_req[23:4] == m_cur[23:4]) && !q.bus_off;

  always_comb begin
    n          = q;
    n.rsp_v    = 1'b0;
    n.skip     = 1'b0;
    req_ready  = 1'b0;
    n.wait_s1  = wait_in;
    n.wait_s2  = q.wait_s1;
    n.xsel_s1  = external_code_select_n;
    n.xsel_s2  = q.xsel_s1;
    n.bw_s1    = width_select_pin;
    n.bw_s2    = q.bw_s1;
    n.din_s1   = mux_in;
    n.din_s2   = q.din_s1;

    // ================================================================
    // Strap capture once the synchronisers hold the released levels
    if (q.strap_cnt != 2'h3)
      n.strap_cnt = q.strap_cnt + 2'h1;
    if (q.strap_cnt == 2'h2) begin
      n.ext_all = !q.xsel_s2;
      n.shape   = q.bw_s2 ? `EMB_SHAPE_16_24 : `EMB_SHAPE_8_24;
    end

    // ================================================================
    // Bus sequencer
    case (q.st)
      emb_pkg::S_IDLE: begin
        req_ready = (q.strap_cnt == 2'h3);
        if (req_valid && req_ready) begin
          if (q.bus_off ||
              (emb_pkg::emb_kind_e'(req_kind) == emb_pkg::K_CODE &&
               !q.ext_all && req_addr < CODE_LIMIT)) begin
            n.rsp_v = 1'b1;
            n.skip  = 1'b1;
          end else begin
            n.kind   = emb_pkg::emb_kind_e'(req_kind);
            n.addr   = req_addr;
            n.word   = req_word;
            n.wdata  = req_wdata;
            n.second = 1'b0;
            n.mux    = m_req[19:4];
            n.cnt    = ALE_LD;
            n.st     = emb_pkg::S_ALE;
          end
        end
      end
      emb_pkg::S_ALE: begin
        if (q.cnt != 4'h0) begin
          n.cnt = q.cnt - 4'h1;
        end else begin
          n.cnt = STRB_LD;
          n.st  = emb_pkg::S_STRB;
          if (q.kind == emb_pkg::K_WRITE)
            n.mux = lane(bus16, q.word, q.addr[0], 1'b0, q.wdata);
        end
      end
      emb_pkg::S_STRB: begin
        if (q.cnt != 4'h0) begin
          n.cnt = q.cnt - 4'h1;
        end else if (!wait_act) begin
          if (!bus16) begin
            if (q.second)
              n.rdata[15:8] = byte_in;
            else
              n.rdata = {8'h00, byte_in};
          end else begin
            n.rdata = q.din_s2;
          end
          if (!bus16 && q.word && !q.second) begin
            n.second  = 1'b1;
            n.addr[0] = 1'b1;
            n.st      = emb_pkg::S_REST;
          end else begin
            n.rsp_v  = 1'b1;
            n.second = 1'b0;
            if (burst_ok) begin
              req_ready = 1'b1;
              n.addr    = req_addr;
              n.word    = req_word;
              n.cnt     = STRB_LD;
            end else begin
              n.st = emb_pkg::S_REST;
            end
          end
        end
      end
      emb_pkg::S_REST: begin
        if (q.second) begin
          n.cnt = STRB_LD;
          n.st  = emb_pkg::S_STRB;
          if (q.kind == emb_pkg::K_WRITE)
            n.mux = lane(1'b0, 1'b1, 1'b1, 1'b1, q.wdata);
        end else begin
          n.st = emb_pkg::S_IDLE;
        end
      end
      default: n.st = emb_pkg::S_IDLE;
    endcase

    // Bus off aborts any cycle under way
    if (q.bus_off && (q.st == emb_pkg::S_ALE || q.st == emb_pkg::S_STRB || q.second)) begin
      n.st     = emb_pkg::S_IDLE;
      n.second = 1'b0;
      n.rsp_v  = 1'b1;
      n.skip   = 1'b1;
    end

    // ================================================================
    // AXI4-Lite write path
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got   = 1'b1;
      n.w_data  = s_axi_wdata[7:0];
      n.w_lane0 = s_axi_wstrb[0];
    end
    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `EMB_RESP_SLVERR;
      if (q.aw_addr[7:2] == `EMB_OFS_CFG >> 2) begin
        n.bresp = `EMB_RESP_OKAY;
        if (q.w_lane0) begin
          n.shape    = q.w_data[2:0];
          n.wait_ign = q.w_data[`EMB_CFG_WIGN];
          n.bus_off  = q.bus_off | q.w_data[`EMB_CFG_OFF];
        end
      end else if (q.aw_addr[7:2] == `EMB_OFS_STATUS >> 2) begin
        n.bresp = `EMB_RESP_OKAY;
      end
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;

    // ================================================================
    // AXI4-Lite read path
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `EMB_RESP_OKAY;
      n.rdat   = 32'h0;
      if (s_axi_araddr[7:2] == `EMB_OFS_CFG >> 2)
        n.rdat[7:0] = {3'h0, q.wait_ign, q.bus_off, q.shape};
      else if (s_axi_araddr[7:2] == `EMB_OFS_STATUS >> 2)
        n.rdat[3:0] = {q.st != emb_pkg::S_IDLE, bus16, q.ext_all,
                       q.strap_cnt == 2'h3};
      else
        n.rresp = `EMB_RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q           <= '0;
      q.st        <= emb_pkg::S_IDLE;
      q.kind      <= emb_pkg::K_CODE;
      q.shape     <= `EMB_SHAPE_16_24;
    end else begin
      q <= n;
    end
  end

  // ==================================================================
  // Outputs
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdat;
  assign s_axi_rresp   = q.rresp;
  assign rsp_valid     = q.rsp_v;
  assign rsp_skip      = q.skip;
  assign rsp_rdata     = q.rdata;

  // Strobes gated by bus off so a late write cannot leave one low
  assign addr_latch_en = !q.bus_off && q.st == emb_pkg::S_ALE;
  assign code_fetch_strobe_n = !(running && q.kind == emb_pkg::K_CODE);
  assign read_strobe_n = !(running && q.kind == emb_pkg::K_READ);
  assign low_byte_write_strobe_n = !(running && q.kind == emb_pkg::K_WRITE
                                     && (!bus16 || q.word || !q.addr[0]));
  assign high_byte_write_strobe_n = !(running && q.kind == emb_pkg::K_WRITE
                                      && bus16 && (q.word || q.addr[0]));
  assign addr_low      = m_cur[3:0];
  assign addr_top      = m_cur[23:20];
  assign mux_out       = q.mux;
  assign mux_oe        = !q.bus_off && (q.st == emb_pkg::S_ALE
                         || (q.st == emb_pkg::S_STRB && q.kind == emb_pkg::K_WRITE));

endmodule // emb_bus_if

/* core/emb_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts
  of the external memory bus interface.
  Assumes a 125 MHz core clock and a byte-addressed AXI4-Lite slave.
*/
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

// ====================================================================
// Register map
`define EMB_OFS_CFG      8'h00
`define EMB_OFS_STATUS   8'h04
`define EMB_CFG_RESET    8'h00
`define EMB_CFG_WIGN     4
`define EMB_CFG_OFF      3
`define EMB_SHAPE_8_24   3'h3
`define EMB_SHAPE_16_24  3'h7
`define EMB_RESP_OKAY    2'h0
`define EMB_RESP_SLVERR  2'h2

// ====================================================================
// Timing
`define EMB_CLK_NS       8
`define EMB_ALE_NS       16
`define EMB_STRB_NS      40
`define EMB_ALE_CYC      ((`EMB_ALE_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)
`define EMB_STRB_CYC     ((`EMB_STRB_NS + `EMB_CLK_NS - 1) / `EMB_CLK_NS)

`endif

/* core/emb_pkg.sv */
/*
  Types of the external memory bus interface.
  Assumes nothing beyond the register header.
*/
package emb_pkg;

  // ==================================================================
  // Enumerations
  typedef enum logic [1:0] {K_CODE, K_READ, K_WRITE} emb_kind_e;
  typedef enum logic [1:0] {S_IDLE, S_ALE, S_STRB, S_REST} emb_state_e;

  // ==================================================================
  // Whole state of the block
  typedef struct packed {
    emb_state_e st;
    logic [3:0] cnt;
    emb_kind_e  kind;
    logic [23:0] addr;
    logic       word;
    logic [15:0] wdata;
    logic       second;
    logic [15:0] rdata;
    logic [15:0] mux;
    logic       rsp_v;
    logic       skip;
    logic       ext_all;
    logic [2:0] shape;
    logic       wait_ign;
    logic       bus_off;
    logic [1:0] strap_cnt;
    logic       wait_s1;
    logic       wait_s2;
    logic       xsel_s1;
    logic       xsel_s2;
    logic       bw_s1;
    logic       bw_s2;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } emb_state_s;

endpackage

/* sim/emb_bus_if_asserts.sv */
/*
  Pin-level checker of emb_bus_if, bound to every instance.
  Assumes default ALE_CYC of 2 and STRB_CYC of 5 cycles.
*/
`timescale 1ns/10ps
module emb_bus_if_chk (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       code_fetch_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       low_byte_write_strobe_n,
  input wire logic       high_byte_write_strobe_n,
  input wire logic       addr_latch_en,
  input wire logic [3:0] addr_low,
  input wire logic       mux_oe,
  input wire logic       rsp_valid,
  input wire logic       rsp_skip
);
  wire logic wr_idle = low_byte_write_strobe_n && high_byte_write_strobe_n;
  wire logic busy = !(wr_idle && read_strobe_n && code_fetch_strobe_n);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==================================================================
  // Strobe and latch relations
  AST_CODE_EXCL: assert property (!code_fetch_strobe_n |->
      read_strobe_n && wr_idle && !mux_oe)
    else $error("code strobe overlaps other activity");
  AST_READ_EXCL: assert property (!read_strobe_n |-> wr_idle && !mux_oe)
    else $error("read strobe overlaps a write or a driven bus");
  AST_WRITE_DRIVES: assert property (!wr_idle |-> mux_oe && read_strobe_n)
    else $error("write strobe without driven data");
  AST_ALE_CLEAN: assert property (addr_latch_en |-> !busy && mux_oe)
    else $error("latch pulse during a strobe or undriven bus");
  AST_ALE_THEN_STROBE: assert property ($rose(addr_latch_en) |=>
      addr_latch_en ##1 (!addr_latch_en && busy))
    else $error("latch pulse not followed by a strobe");
  AST_ADDR_HELD: assert property (!wr_idle && !$past(wr_idle) |-> $stable(addr_low))
    else $error("low address lines moved during a write");
  AST_REST_CLOCK: assert property ($fell(busy) |-> !addr_latch_en ##1 !addr_latch_en)
    else $error("no idle clock after a bus cycle");
  AST_SKIP_QUIET: assert property (rsp_valid && rsp_skip |-> !busy && !addr_latch_en)
    else $error("bus activity on a skipped access");
  AST_WRITE_LENGTH: assert property ($fell(wr_idle) |-> (!wr_idle)[*5])
    else $error("write strobe shorter than its programmed length");

  C_WORD16: cover property (!low_byte_write_strobe_n && !high_byte_write_strobe_n);
  C_READ: cover property (rsp_valid && !rsp_skip);
  C_SKIP: cover property (rsp_valid && rsp_skip);
endmodule // emb_bus_if_chk

bind emb_bus_if emb_bus_if_chk u_chk (.core_clk, .sys_rst, .code_fetch_strobe_n, .read_strobe_n,
  .low_byte_write_strobe_n, .high_byte_write_strobe_n, .addr_latch_en, .addr_low, .mux_oe,
  .rsp_valid, .rsp_skip);

/* sim/emb_ext_mem.sv */
/*
  External latch, 256-byte memory and wait generator on the bus pins.
  Assumes address bits 7:4 arrive on the multiplexed lines during the latch pulse.
*/
`timescale 1ns/10ps
module emb_ext_mem (
  input  wire logic        core_clk,
  input  wire logic        bw16,
  input  wire logic [3:0]  wait_len,
  input  wire logic        code_fetch_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        low_byte_write_strobe_n,
  input  wire logic        high_byte_write_strobe_n,
  input  wire logic        addr_latch_en,
  input  wire logic [3:0]  addr_low,
  input  wire logic [15:0] mux_out,
  output      logic [15:0] mux_in,
  output      logic        wait_in
);
  logic [7:0]  mem [256];
  logic [15:0] lat_q, wd_q;
  logic [7:0]  wa_q;
  logic [3:0]  wcnt_q = 4'h0;
  logic        lw_q = 1'b1, hw_q = 1'b1, act_q = 1'b0;
  wire logic [7:0] a = {lat_q[3:0], addr_low};
  wire logic rd_on = !code_fetch_strobe_n || !read_strobe_n;
  wire logic act = rd_on || !low_byte_write_strobe_n || !high_byte_write_strobe_n;

  // ==================================================================
  // Bus side
  initial foreach (mem[i]) mem[i] = 8'h00;
  initial mux_in = 16'h0000;
  always @(posedge core_clk) begin
    if (addr_latch_en) lat_q <= mux_out;
    // Released lines show a changing pattern, not the last value
    if (rd_on) mux_in <= bw16 ? {mem[a | 8'h01], mem[a & 8'hfe]} : {8'h00, mem[a]};
    else mux_in <= ~mux_in;
    if (!low_byte_write_strobe_n || !high_byte_write_strobe_n) begin
      wd_q <= mux_out;
      wa_q <= a;
    end
    lw_q <= low_byte_write_strobe_n;
    hw_q <= high_byte_write_strobe_n;
    if (low_byte_write_strobe_n && !lw_q) mem[bw16 ? wa_q & 8'hfe : wa_q] <= wd_q[7:0];
    if (high_byte_write_strobe_n && !hw_q) mem[wa_q | 8'h01] <= wd_q[15:8];
    act_q <= act;
    if (act && !act_q) wcnt_q <= wait_len;
    else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
  end
  assign wait_in = wcnt_q != 4'h0;
endmodule // emb_ext_mem

/* sim/tb_external_memory_bus_interface.sv */
/*
  Self-checking bench of emb_bus_if with the external memory model.
  Assumes default timing parameters and a 125 MHz core clock.
*/
`timescale 1ns/10ps
module tb_external_memory_bus_interface;
  logic        core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, req_valid, req_word, external_code_select_n, width_select_pin;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        req_ready, rsp_valid, rsp_skip, code_fetch_strobe_n, read_strobe_n;
  logic        low_byte_write_strobe_n, high_byte_write_strobe_n, addr_latch_en, mux_oe;
  logic        wait_in, bw16, sk, ale_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, req_kind;
  logic [3:0]  addr_low, addr_top, wait_len, s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] req_wdata, rsp_rdata, mux_out, mux_in, rsd;
  logic [23:0] req_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_fail = 0, comparisons = 0, ale_n = 0, strb_n = 0, s0, a0;

  emb_bus_if dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_kind, .req_addr,
    .req_word, .req_wdata, .rsp_valid, .rsp_skip, .rsp_rdata, .code_fetch_strobe_n,
    .read_strobe_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n, .addr_latch_en,
    .addr_low, .addr_top, .mux_out, .mux_oe, .mux_in, .wait_in, .external_code_select_n,
    .width_select_pin);
  emb_ext_mem u_mem (.core_clk, .bw16, .wait_len, .code_fetch_strobe_n, .read_strobe_n,
    .low_byte_write_strobe_n, .high_byte_write_strobe_n, .addr_latch_en, .addr_low,
    .mux_out, .mux_in, .wait_in);

  // ==================================================================
  // Clock, pin monitor, watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial ale_d = 1'b0;
  always @(posedge core_clk) begin
    ale_d <= addr_latch_en;
    if (addr_latch_en && !ale_d) ale_n <= ale_n + 1;
    if (!(read_strobe_n && code_fetch_strobe_n && low_byte_write_strobe_n
          && high_byte_write_strobe_n)) strb_n <= strb_n + 1;
  end
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  // ==================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge core_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'h0);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    chk(s_axi_rdata, ed);
  endtask
  task automatic rq(input logic [1:0] k, input logic [23:0] a, input logic w,
                    input logic [15:0] d);
    @(posedge core_clk);
    {req_valid, req_kind, req_addr, req_word, req_wdata} <= {1'b1, k, a, w, d};
    do @(posedge core_clk); while (!req_ready);
    req_valid <= 1'b0;
    do @(posedge core_clk); while (!rsp_valid);
    rsd = rsp_rdata;
    sk = rsp_skip;
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_regs();
    axr(8'h00, 32'h7, 2'h0);
    s_axi_wstrb <= 4'h0;
    axw(8'h00, 32'h10);
    s_axi_wstrb <= 4'hf;
    axr(8'h00, 32'h7, 2'h0);
    axr(8'h04, 32'h5, 2'h0);
    axr(8'h08, 32'h0, 2'h2);
  endtask
  task automatic t_write16();
    a0 = ale_n;
    rq(2'h2, 24'h000010, 1'b1, 16'ha55a);
    rq(2'h2, 24'h000013, 1'b0, 16'h0077);
    rq(2'h1, 24'h000012, 1'b0, 16'h0000);
    chk(rsd, 16'h7700);
    rq(2'h1, 24'h000010, 1'b1, 16'h0000);
    chk(rsd, 16'ha55a);
    chk(ale_n - a0, 4);
  endtask
  task automatic t_code();
    rq(2'h2, 24'h008024, 1'b1, 16'h1234);
    rq(2'h0, 24'h000100, 1'b1, 16'h0000);
    chk(sk, 1'b1);
    rq(2'h0, 24'h008024, 1'b1, 16'h0000);
    chk({sk, rsd}, {1'b0, 16'h1234});
  endtask
  // Second code request held valid across the first strobe: one latch pulse
  task automatic t_burst();
    rq(2'h2, 24'h008026, 1'b1, 16'h5678);
    a0 = ale_n;
    @(posedge core_clk);
    {req_valid, req_kind, req_addr, req_word} <= {1'b1, 2'h0, 24'h008024, 1'b1};
    do @(posedge core_clk); while (!req_ready);
    req_addr <= 24'h008026;
    do @(posedge core_clk); while (!req_ready);
    req_valid <= 1'b0;
    do @(posedge core_clk); while (!rsp_valid);
    chk(rsp_rdata, 16'h1234);
    do @(posedge core_clk); while (!rsp_valid);
    chk(rsp_rdata, 16'h5678);
    chk(ale_n - a0, 1);
  endtask
  task automatic t_wait();
    wait_len <= 4'h6;
    s0 = strb_n;
    rq(2'h1, 24'h000010, 1'b1, 16'h0000);
    chk(strb_n - s0 > 6, 1);
    axw(8'h00, 32'h17);
    s0 = strb_n;
    rq(2'h1, 24'h000010, 1'b1, 16'h0000);
    chk(strb_n - s0, 5);
  endtask
  task automatic t_bus8();
    bw16 <= 1'b0;
    axw(8'h00, 32'h13);
    axr(8'h00, 32'h13, 2'h0);
    {a0, s0} = {ale_n, strb_n};
    rq(2'h2, 24'h000030, 1'b1, 16'hbeef);
    chk(ale_n - a0, 1);
    chk(strb_n - s0, 10);
    rq(2'h1, 24'h000030, 1'b1, 16'h0000);
    chk(rsd, 16'hbeef);
  endtask
  task automatic t_bus_off();
    axw(8'h00, 32'h1b);
    {a0, s0} = {ale_n, strb_n};
    rq(2'h1, 24'h000040, 1'b0, 16'h0000);
    chk(sk, 1'b1);
    chk(ale_n - a0 + strb_n - s0, 0);
    axw(8'h00, 32'h13);
    axr(8'h00, 32'h1b, 2'h0);
  endtask
  task automatic t_strap();
    @(posedge core_clk);
    {sys_rst, external_code_select_n, width_select_pin} <= 3'h4;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    {external_code_select_n, width_select_pin} <= 2'h3;
    axr(8'h04, 32'h3, 2'h0);
    axr(8'h00, 32'h3, 2'h0);
    rq(2'h0, 24'h000024, 1'b1, 16'h0000);
    chk({sk, rsd}, {1'b0, 16'h1234});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {req_valid, req_word, req_kind, req_addr, req_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sys_rst, external_code_select_n, width_select_pin, bw16, wait_len} = 8'hf0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    t_regs();
    t_write16();
    t_code();
    t_burst();
    t_wait();
    t_bus8();
    t_bus_off();
    t_strap();
    print_verdict();
  end
endmodule // tb_external_memory_bus_interface
